// ===== hdl/ovl_ctrl.sv
// output-4 driver, oscillator power and lock monitor registers on ahb-lite
//
// Function
// - swing trim codes 0..3 give 0.8 to 1.1 V, reset code 10.
// - bit3 termination (0), bit2 regulator (1), bit1 output enable (0).
// - writing one to bit0 pulses divider clear at once; bit self-clears.
// - skip bit 0 waits 2 s at start-up; 1 skips the wait.
// - power select 0 low power, 1 high power; resets to 1.
// - start bit 4 enables monitor immediately once the settle wait is over; resets to 0.
// - codes 0..3 give 15/60/238/954 ppb at 670/170/42/10 ms.
// - codes 4..7 give 3.8/15/61/244 ppm at 2.6 ms..41 us.
// - threshold field bits 3:1, resets to code 110.
// - bit0 of lock register disables the monitor when 1; resets 0.
// - read-only done flag shows a measurement has completed.
// - read-only locked flag, 1 locked and 0 unlocked.
//
// Chosen here: register access over AHB-Lite.
`default_nettype none
module ovl_ctrl #(
  parameter logic [31:0] SETTLE_CYC = ovl_pkg::SETTLE_CYC,
  parameter logic [7:0][31:0] INTERVAL_CYC = ovl_pkg::INTERVAL_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [ovl_pkg::ERR_W-1:0] freq_error_ppb,
  output logic [1:0] output_swing_trim,
  output logic on_chip_termination_enable,
  output logic output_regulator_enable,
  output logic channel_output_enable,
  output logic channel_divider_clear,
  output logic oscillator_power_select,
  output logic oscillator_settle_done,
  output logic lock_monitor_active,
  output logic loop_locked,
  output logic lock_measure_done,
  output logic irq
);
  ovl_pkg::ovl_state_t s;
  ovl_pkg::ovl_state_t n;
  logic [ovl_pkg::ERR_W-1:0] err_sync;
  logic [ovl_pkg::IRQ_W-1:0] ev;
  logic [ovl_pkg::IRQ_W-1:0] w1c;
  logic run;
  logic addr_phase;
  logic meas_now;

  ovl_sync u_err_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(freq_error_ppb),
    .q(err_sync)
  );

  function automatic logic [31:0] interval_of(input logic [2:0] code);
    return INTERVAL_CYC[code];
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] idx,
                                           input ovl_pkg::ovl_state_t st);
    logic [31:0] r;
    r = '0;
    case (idx)
      ovl_pkg::IDX_DRV: r[7:0] = st.drv;
      ovl_pkg::IDX_OSC: r[7:0] = st.osc;
      ovl_pkg::IDX_LOCK: r[7:0] = st.lock;
      ovl_pkg::IDX_READBACK: begin
        r[ovl_pkg::RB_DONE_BIT] = st.done;
        r[ovl_pkg::RB_LOCKED_BIT] = st.locked;
      end
      ovl_pkg::IDX_IRQ_STS: r[ovl_pkg::IRQ_W-1:0] = st.irq_sts;
      ovl_pkg::IDX_IRQ_MASK: r[ovl_pkg::IRQ_W-1:0] = st.irq_mask;
      default: r = '0;
    endcase
    return r;
  endfunction

  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    n = s;
    ev = '0;
    w1c = '0;
    run = 1'b0;
    meas_now = 1'b0;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    n.div_clear = 1'b0;
    n.wr_pend = 1'b0;

    // data phase of a write taken in the previous cycle
    if (s.wr_pend) begin
      case (s.wr_idx)
        ovl_pkg::IDX_DRV: begin
          n.drv = ovl_pkg::ovl_drv_t'(hwdata[7:0]);
          n.drv.rsvd = '0;
          n.drv.clear = 1'b0;
          n.div_clear = hwdata[0];
        end
        ovl_pkg::IDX_OSC: begin
          n.osc = ovl_pkg::ovl_osc_t'(hwdata[7:0]);
          n.osc.rsvd = '0;
        end
        ovl_pkg::IDX_LOCK: begin
          n.lock = ovl_pkg::ovl_lock_t'(hwdata[7:0]);
          n.lock.rsvd = '0;
        end
        ovl_pkg::IDX_IRQ_STS: w1c = hwdata[ovl_pkg::IRQ_W-1:0];
        ovl_pkg::IDX_IRQ_MASK: n.irq_mask = hwdata[ovl_pkg::IRQ_W-1:0];
        default: n.wr_pend = 1'b0;
      endcase
    end

    // start-up settle wait; the skip bit may be set during the wait
    if (!s.settle_done) begin
      if (n.osc.skip || s.settle_cnt == SETTLE_CYC - 32'd1) begin
        n.settle_done = 1'b1;
      end else begin
        n.settle_cnt = s.settle_cnt + 32'd1;
      end
    end

    // start and disable act without any transfer strobe
    run = n.lock.start && !n.lock.off &&
          s.settle_done;
    n.active = run;
    if (!run) begin
      // a stopped monitor forgets its result; a restart measures afresh
      n.meas_cnt = '0;
      n.done = 1'b0;
      n.locked = 1'b0;
    end else begin
      // >= so that shortening the interval mid-count cannot overrun it
      meas_now = s.meas_cnt >=
        interval_of(n.lock.thr) - 32'd1;
      if (meas_now) begin
        n.meas_cnt = '0;
        n.done = 1'b1;
        // nominal limit only; the analog detector itself is +-25% wide
        n.locked = err_sync <=
          ovl_pkg::THRESH_PPB[n.lock.thr];
        ev[ovl_pkg::IRQ_DONE_BIT] = 1'b1;
        ev[ovl_pkg::IRQ_LOSS_BIT] = s.locked && !n.locked;
        ev[ovl_pkg::IRQ_GAIN_BIT] = !s.locked && n.locked;
      end else begin
        n.meas_cnt = s.meas_cnt + 32'd1;
      end
    end

    // an event in the clearing cycle survives the clear
    n.irq_sts = (s.irq_sts & ~w1c) | ev;
    n.irq = |(n.irq_sts & n.irq_mask);

    // address phase; read data reflects any write landing this cycle
    if (addr_phase) begin
      n.wr_pend = hwrite;
      n.wr_idx = haddr[9:2];
      if (!hwrite) begin
        n.hrdata = read_mux(haddr[9:2], n);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= ovl_pkg::STATE_RESET;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign output_swing_trim = s.drv.trim;
  assign on_chip_termination_enable = s.drv.term;
  assign output_regulator_enable = s.drv.reg_en;
  assign channel_output_enable = s.drv.out_en;
  assign channel_divider_clear = s.div_clear;
  assign oscillator_power_select = s.osc.power;
  assign oscillator_settle_done = s.settle_done;
  assign lock_monitor_active = s.active;
  assign loop_locked = s.locked;
  assign lock_measure_done = s.done;
  assign irq = s.irq;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic wr_drv;
  logic wr_osc;
  logic wr_lock;
  logic rd_back;
  assign wr_drv = s.wr_pend && s.wr_idx == ovl_pkg::IDX_DRV;
  assign wr_osc = s.wr_pend && s.wr_idx == ovl_pkg::IDX_OSC;
  assign wr_lock = s.wr_pend && s.wr_idx == ovl_pkg::IDX_LOCK;
  assign rd_back = addr_phase && !hwrite &&
                   haddr[9:2] == ovl_pkg::IDX_READBACK;

  property p_trim_write;
    wr_drv |=> output_swing_trim == $past(hwdata[5:4]);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("swing trim did not follow write");

  property p_bits_write;
    wr_drv |=> on_chip_termination_enable == $past(hwdata[3]) &&
               output_regulator_enable == $past(hwdata[2]) &&
               channel_output_enable == $past(hwdata[1]);
  endproperty
  a_bits_write: assert property (p_bits_write)
    else $error("driver enables did not follow write");

  property p_clear_pulse;
    wr_drv && hwdata[0] |=> channel_divider_clear && s.drv.clear == 1'b0;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("divider clear missing after write");

  property p_clear_src;
    channel_divider_clear |-> $past(wr_drv) && $past(hwdata[0]);
  endproperty
  a_clear_src: assert property (p_clear_src)
    else $error("divider clear without a write");

  property p_settle;
    $rose(oscillator_settle_done) |->
      $past(n.osc.skip) || $past(s.settle_cnt) == SETTLE_CYC - 32'd1;
  endproperty
  a_settle: assert property (p_settle)
    else $error("settle wait ended early");

  property p_power;
    wr_osc |=> oscillator_power_select == $past(hwdata[0]);
  endproperty
  a_power: assert property (p_power)
    else $error("power select did not follow write");

  property p_start;
    wr_lock && hwdata[4] && !hwdata[0] && s.settle_done |=>
      lock_monitor_active;
  endproperty
  a_start: assert property (p_start)
    else $error("monitor not started at once");

  property p_disable;
    wr_lock && hwdata[0] |=> !lock_monitor_active;
  endproperty
  a_disable: assert property (p_disable)
    else $error("monitor active while disabled");

  property p_disable_hold;
    s.lock.off |-> !lock_monitor_active;
  endproperty
  a_disable_hold: assert property (p_disable_hold)
    else $error("monitor running with disable set");

  property p_active_settle;
    lock_monitor_active |-> oscillator_settle_done;
  endproperty
  a_active_settle: assert property (p_active_settle)
    else $error("monitor running before settle wait ended");

  property p_done;
    $rose(lock_measure_done) |->
      $past(s.meas_cnt) >= interval_of(s.lock.thr) - 32'd1;
  endproperty
  a_done: assert property (p_done)
    else $error("measurement done before interval end");

  property p_readback;
    rd_back |=> hrdata[4] == lock_measure_done && hrdata[2] == loop_locked;
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback flags disagree with status");

  property p_sts_set;
    meas_now |=> s.irq_sts[ovl_pkg::IRQ_DONE_BIT];
  endproperty
  a_sts_set: assert property (p_sts_set)
    else $error("done event lost from interrupt status");

  // a write landing in the compare cycle may move the threshold, so skip it
  property p_lock_cmp;
    meas_now && !wr_lock |=> loop_locked ==
      ($past(err_sync) <= ovl_pkg::THRESH_PPB[s.lock.thr]);
  endproperty
  a_lock_cmp: assert property (p_lock_cmp)
    else $error("locked flag does not match threshold compare");

endmodule // ovl_ctrl
`default_nettype wire

// ===== hdl/ovl_pkg.sv
// shared constants and types for the output-4 / oscillator / lock monitor bank
`default_nettype none
package ovl_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DRV = 8'h1b;
  localparam logic [7:0] IDX_OSC = 8'h1c;
  localparam logic [7:0] IDX_LOCK = 8'h1d;
  localparam logic [7:0] IDX_READBACK = 8'h1f;
  localparam logic [7:0] IDX_IRQ_STS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  localparam logic [9:0] ADDR_DRV = {IDX_DRV, 2'b00};
  localparam logic [9:0] ADDR_OSC = {IDX_OSC, 2'b00};
  localparam logic [9:0] ADDR_LOCK = {IDX_LOCK, 2'b00};
  localparam logic [9:0] ADDR_READBACK = {IDX_READBACK, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STS = {IDX_IRQ_STS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // field layouts, msb first
  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] trim;
    logic term;
    logic reg_en;
    logic out_en;
    logic clear;
  } ovl_drv_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic skip;
    logic power;
  } ovl_osc_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic start;
    logic [2:0] thr;
    logic off;
  } ovl_lock_t;

  // readback register bit positions
  localparam int unsigned RB_DONE_BIT = 4;
  localparam int unsigned RB_LOCKED_BIT = 2;

  // interrupt status / mask bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_LOSS_BIT = 1;
  localparam int unsigned IRQ_GAIN_BIT = 2;

  localparam ovl_drv_t DRV_RESET = 8'h24;
  localparam ovl_osc_t OSC_RESET = 8'h01;
  localparam ovl_lock_t LOCK_RESET = 8'h0c;

  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SETTLE_S = 2;
  localparam logic [31:0] SETTLE_CYC = 32'(SETTLE_S * CLK_MHZ * 1000000);
  // update interval per threshold code, in microseconds, code 7 first
  localparam logic [7:0][31:0] INTERVAL_US = {
    32'd41, 32'd160, 32'd660, 32'd2600,
    32'd10000, 32'd42000, 32'd170000, 32'd670000};

  function automatic logic [7:0][31:0] interval_cycles();
    logic [7:0][31:0] c;
    c = '0;
    for (int i = 0; i < 8; i++) begin
      c[i] = 32'(INTERVAL_US[i] * CLK_MHZ);
    end
    return c;
  endfunction

  localparam logic [7:0][31:0] INTERVAL_CYC = interval_cycles();

  // frequency error thresholds in ppb, code 7 first
  localparam int unsigned ERR_W = 18;
  localparam logic [7:0][ERR_W-1:0] THRESH_PPB = {
    18'd244000, 18'd61000, 18'd15000, 18'd3800,
    18'd954, 18'd238, 18'd60, 18'd15};

  typedef struct packed {
    logic [ERR_W-1:0] ff1;
    logic [ERR_W-1:0] ff2;
    logic [ERR_W-1:0] ff3;
    logic [ERR_W-1:0] q;
  } ovl_sync_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_idx;
    ovl_drv_t drv;
    logic div_clear;
    ovl_osc_t osc;
    ovl_lock_t lock;
    logic settle_done;
    logic [31:0] settle_cnt;
    logic active;
    logic [31:0] meas_cnt;
    logic locked;
    logic done;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } ovl_state_t;

  localparam ovl_state_t STATE_RESET = '{
    hreadyout: 1'b1, drv: DRV_RESET, osc: OSC_RESET, lock: LOCK_RESET,
    default: '0};

endpackage
`default_nettype wire

// ===== hdl/ovl_sync.sv
// three-stage synchroniser for the measured frequency error word
`default_nettype none
module ovl_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [ovl_pkg::ERR_W-1:0] d,
  output logic [ovl_pkg::ERR_W-1:0] q
);
  ovl_pkg::ovl_sync_t s;
  ovl_pkg::ovl_sync_t n;

  always_comb begin
    n = s;
    n.ff1 = d;
    n.ff2 = s.ff1;
    n.ff3 = s.ff2;
    // a word only counts once two later stages agree, so a torn sample
    // caught mid-change never reaches the comparator
    if (s.ff2 == s.ff3) begin
      n.q = s.ff3;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q = s.q;
endmodule // ovl_sync
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the driver, oscillator and lock monitor bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts so every interval fits a quick run; code c waits 12+4c
  localparam logic [7:0][31:0] ICYC = {32'd40, 32'd36, 32'd32, 32'd28,
    32'd24, 32'd20, 32'd16, 32'd12};
  localparam logic [7:0][17:0] THR = {18'd244000, 18'd61000, 18'd15000,
    18'd3800, 18'd954, 18'd238, 18'd60, 18'd15};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [17:0] ferr = 18'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, term, regen, oen, dclr, pwr, sdone;
  logic mact, lkd, mdone, irq;
  logic [1:0] trim;
  int mismatches = 0;
  int n_compared = 0;

  always #2.5 hclk = ~hclk;

  ovl_ctrl #(.SETTLE_CYC(32'd50), .INTERVAL_CYC(ICYC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .freq_error_ppb(ferr), .output_swing_trim(trim),
    .on_chip_termination_enable(term), .output_regulator_enable(regen),
    .channel_output_enable(oen), .channel_divider_clear(dclr),
    .oscillator_power_select(pwr), .oscillator_settle_done(sdone),
    .lock_monitor_active(mact), .loop_locked(lkd),
    .lock_measure_done(mdone), .irq(irq));

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // address phase, then data phase; each held until hready is seen high
  task automatic xfer(input logic [9:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 128);
    rd = hrdata;
    chk(hresp, 1'b0);
    if (n >= 128) begin
      mismatches++;
      results();
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    chk(x, e);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    cycles(16);
    hresetn <= 1'b1;
  endtask

  task automatic test_reset();
    chk(trim, 2'b10);
    chk({term, regen, oen, dclr}, 4'b0100);
    chk(pwr, 1'b1);
    chk({sdone, mact, lkd, mdone, irq}, 5'h0);
    rdchk(ovl_pkg::ADDR_DRV, 32'h24);
    rdchk(ovl_pkg::ADDR_OSC, 32'h01);
    rdchk(ovl_pkg::ADDR_LOCK, 32'h0c);
    rdchk(ovl_pkg::ADDR_READBACK, 32'h0);
    rdchk(ovl_pkg::ADDR_IRQ_MASK, 32'h0);
    wr(10'h000, 32'hff);
    rdchk(10'h000, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_settle();
    int n;
    n = 0;
    do_reset();
    while (sdone !== 1'b1 && n < 100) begin @(posedge hclk); n++; end
    chk(n >= 48 && n <= 53, 1'b1);
    if (sdone !== 1'b1) results();
    do_reset();
    cycles(2);
    wr(ovl_pkg::ADDR_OSC, 32'h02);
    cycles(2);
    chk({sdone, pwr}, 2'b10);
    rdchk(ovl_pkg::ADDR_OSC, 32'h02);
    wr(ovl_pkg::ADDR_OSC, 32'h03);
    cycles(1);
    chk(pwr, 1'b1);
    $display("test_settle done");
  endtask

  task automatic test_drv();
    logic [31:0] d;
    int p;
    p = 0;
    for (int t = 0; t < 4; t++) begin
      d = {26'h0, 2'(t), t[0], ~t[0], t[1], 1'b0};
      wr(ovl_pkg::ADDR_DRV, d);
      cycles(1);
      chk({trim, term, regen, oen}, d[5:1]);
      rdchk(ovl_pkg::ADDR_DRV, d);
    end
    wr(ovl_pkg::ADDR_DRV, 32'h25);
    repeat (4) begin @(posedge hclk); p += (dclr === 1'b1); end
    chk(p, 1);
    rdchk(ovl_pkg::ADDR_DRV, 32'h24);
    $display("test_drv done");
  endtask

  task automatic test_lock();
    logic [31:0] d;
    for (int c = 0; c < 8; c++) begin
      d = {27'h0, 1'b1, 3'(c), 1'b0};
      ferr <= THR[c];
      wr(ovl_pkg::ADDR_LOCK, d);
      cycles(1);
      chk(mact, 1'b1);
      cycles(ICYC[c] + 8);
      chk({lkd, mdone}, 2'b11);
      rdchk(ovl_pkg::ADDR_READBACK, 32'h14);
      ferr <= THR[c] + 18'h1;
      cycles(ICYC[c] + 8);
      chk({lkd, mdone}, 2'b01);
      rdchk(ovl_pkg::ADDR_LOCK, d);
      wr(ovl_pkg::ADDR_LOCK, 32'h0);
      cycles(1);
      chk({mact, lkd, mdone}, 3'h0);
    end
    $display("test_lock done");
  endtask

  task automatic test_disable();
    ferr <= 18'h0;
    wr(ovl_pkg::ADDR_LOCK, 32'h15);
    cycles(ICYC[2] + 8);
    chk({mact, lkd, mdone}, 3'h0);
    wr(ovl_pkg::ADDR_LOCK, 32'h14);
    cycles(1);
    chk(mact, 1'b1);
    wr(ovl_pkg::ADDR_LOCK, 32'h0);
    $display("test_disable done");
  endtask

  task automatic test_irq();
    logic [31:0] x;
    rdchk(ovl_pkg::ADDR_IRQ_STS, 32'h7);
    wr(ovl_pkg::ADDR_IRQ_STS, 32'h7);
    ferr <= 18'h0;
    wr(ovl_pkg::ADDR_LOCK, 32'h1e);
    cycles(ICYC[7] + 8);
    wr(ovl_pkg::ADDR_LOCK, 32'h0);
    xfer(ovl_pkg::ADDR_IRQ_STS, 1'b0, 32'h0, x);
    chk(x & 32'h5, 32'h5);
    chk(irq, 1'b0);
    wr(ovl_pkg::ADDR_IRQ_MASK, 32'h1);
    cycles(2);
    chk(irq, 1'b1);
    // writing ones clears every status bit at once
    wr(ovl_pkg::ADDR_IRQ_STS, 32'h7);
    cycles(2);
    chk(irq, 1'b0);
    rdchk(ovl_pkg::ADDR_IRQ_STS, 32'h0);
    rdchk(ovl_pkg::ADDR_IRQ_MASK, 32'h1);
    $display("test_irq done");
  endtask

  initial begin
    do_reset();
    @(posedge hclk);
    test_reset();
    test_settle();
    test_drv();
    test_lock();
    test_disable();
    test_irq();
    results();
  end
endmodule // tb
`default_nettype wire
